/* logic/cld_busy_timer.sv */
// Busy timer counting execution time in internal oscillator periods
`timescale 1ns/100ps
`default_nettype none
module cld_busy_timer #(
	parameter int OSC_DIV = cld_pkg::OSC_DIV,
	parameter int TICK_W  = cld_pkg::TICK_W
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Start request with its length in oscillator periods
	input  wire logic              start,
	input  wire logic [TICK_W-1:0] ticks,
	// Running indication
	output var  logic              busy
);

	localparam int DIV_W = $clog2(OSC_DIV);

	typedef struct packed {
		logic [DIV_W-1:0]  div;
		logic [TICK_W-1:0] left;
	} cld_tmr_state_t;

	cld_tmr_state_t q;
	cld_tmr_state_t d;
	logic           osc_tick;

	// The divider restarts with each request, so the length is exact
	always_comb begin
		d = q;
		osc_tick = (q.div == DIV_W'(OSC_DIV - 1));
		if (start) begin
			d.div = '0;
			d.left = ticks;
		end else if (q.left != '0) begin
			if (osc_tick) begin
				d.div = '0;
				d.left = TICK_W'(q.left - 1'b1);
			end else begin
				d.div = DIV_W'(q.div + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy = (q.left != '0);

	// Helper counting the busy length against the requested length
	logic [31:0]       run_cnt;
	logic [TICK_W-1:0] run_ticks;
	always_ff @(posedge clk) begin
		if (rst) begin
			run_cnt <= '0;
			run_ticks <= '0;
		end else if (start) begin
			run_cnt <= '0;
			run_ticks <= ticks;
		end else if (busy) begin
			run_cnt <= run_cnt + 32'd1;
		end
	end

	busy_length_a: assert property (@(posedge clk) disable iff (rst)
		($fell(busy) && !$past(start)) |->
		(run_cnt == 32'(run_ticks) * 32'(OSC_DIV)))
		else $error("busy length does not match oscillator count");

endmodule : cld_busy_timer
`default_nettype wire

/* logic/cld_decoder.sv */
// Instruction decoder and execution sequencer of the display controller
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Clear fills text RAM with spaces, counter zero
// - Clear homes cursor and forces increment mode
// - Home zeroes counter, undoes shift, keeps text
// - Entry mode stores direction and follow shift
// - Display control stores display, cursor, blink
// - Shift moves cursor or display, text kept
// - Function set picks width, lines, glyph height
// - Glyph address load targets glyph RAM
// - Text address load targets text RAM
// - Status read gives busy and address counter
// - Data write stores into last addressed RAM
// - Data read returns addressed RAM byte
// - Counter steps by one after RAM access
// - Busy high during work; host polls it
// - Transfers captured into holding registers first
// - Busy lengths scale with the oscillator rate
// - Direction high increments, low decrements counter
// - Follow shift shifts display on text writes
// - Narrow mode sends bytes as two nibbles
// - Shift target selects cursor or display move
module cld_decoder #(
	parameter int OSC_DIV = cld_pkg::OSC_DIV
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Host bus
	input  wire cld_pkg::cld_host_in_t  host_in,
	output var  cld_pkg::cld_host_out_t host_out,
	// Busy and display settings
	output var  logic                   busy_indicator,
	output var  cld_pkg::cld_cfg_t      cfg
);

	cld_pkg::cld_state_t  q;
	cld_pkg::cld_state_t  d;
	cld_pkg::cld_op_t     op;

	logic [7:0]           text_mem [cld_pkg::TEXT_DEPTH];
	logic [7:0]           glyph_mem [cld_pkg::GLYPH_DEPTH];

	logic                 tmr_busy;
	logic                 tmr_start;
	logic [cld_pkg::TICK_W-1:0] tmr_ticks;

	logic                 text_we;
	logic [6:0]           text_wa;
	logic [7:0]           text_wd;
	logic                 glyph_we;
	logic [7:0]           ram_rd;
	logic [7:0]           rd_byte;
	logic [7:0]           wr_byte;
	logic                 rise;
	logic                 fall;
	logic                 status_rd;
	logic                 full_step;

	cld_busy_timer #(
		.OSC_DIV (OSC_DIV),
		.TICK_W  (cld_pkg::TICK_W)
	) u_timer (
		.clk   (clk),
		.rst   (rst),
		.start (tmr_start),
		.ticks (tmr_ticks),
		.busy  (tmr_busy)
	);

	// Pending work counts as busy so the flag rises at acceptance
	assign busy_indicator = tmr_busy | q.ir_pend | q.dr_pend |
		q.rd_pend | q.clearing;

	assign op = cld_pkg::decode_op(q.instr_holding_reg);
	assign ram_rd = q.to_glyph ? glyph_mem[q.cfg.addr_counter[5:0]] :
		text_mem[q.cfg.addr_counter];

	always_comb begin
		d = q;
		tmr_start = 1'b0;
		tmr_ticks = cld_pkg::TK_INSTR;
		text_we = 1'b0;
		text_wa = q.cfg.addr_counter;
		text_wd = q.data_holding_reg;
		glyph_we = 1'b0;
		rd_byte = 8'h00;
		wr_byte = 8'h00;
		rise = ~q.strobe_prev & host_in.bus_strobe;
		fall = q.strobe_prev & ~host_in.bus_strobe;
		status_rd = ~host_in.reg_select_line & host_in.dir_select_line;
		full_step = q.cfg.bus_width_sel | q.half;
		d.strobe_prev = host_in.bus_strobe;
		d.ir_pend = 1'b0;
		d.dr_pend = 1'b0;
		d.rd_pend = 1'b0;
		d.out.bus_lines_oe = host_in.bus_strobe & host_in.dir_select_line;

		// Read data is latched at the strobe's rising edge
		if (rise & host_in.dir_select_line) begin
			rd_byte = status_rd ? {busy_indicator, q.cfg.addr_counter} :
				ram_rd;
			d.out.bus_lines = full_step & ~q.cfg.bus_width_sel ?
				{rd_byte[3:0], 4'h0} :
				(q.cfg.bus_width_sel ? rd_byte : {rd_byte[7:4], 4'h0});
		end

		// Transfers other than a status read are ignored while busy
		if (fall & (status_rd | ~busy_indicator)) begin
			if (host_in.dir_select_line) begin
				if (full_step) begin
					d.half = 1'b0;
					d.rd_pend = host_in.reg_select_line;
				end else begin
					d.half = 1'b1;
				end
			end else if (full_step) begin
				wr_byte = q.cfg.bus_width_sel ? host_in.bus_lines :
					{q.hi_nib, host_in.bus_lines[7:4]};
				d.half = 1'b0;
				if (host_in.reg_select_line) begin
					d.data_holding_reg = wr_byte;
					d.dr_pend = 1'b1;
				end else begin
					d.instr_holding_reg = wr_byte;
					d.ir_pend = 1'b1;
				end
			end else begin
				d.hi_nib = host_in.bus_lines[7:4];
				d.half = 1'b1;
			end
		end

		// Instruction execution from the holding register
		if (q.ir_pend) begin
			tmr_start = (op != cld_pkg::OP_NONE);
			case (op)
				cld_pkg::OP_CLEAR: begin
					tmr_ticks = cld_pkg::TK_CLEAR;
					d.clearing = 1'b1;
					d.fill = cld_pkg::AC_HOME;
					d.cfg.addr_counter = cld_pkg::AC_HOME;
					d.cfg.display_shift = cld_pkg::SHIFT_HOME;
					d.cfg.step_direction = 1'b1;
					d.to_glyph = 1'b0;
				end
				cld_pkg::OP_HOME: begin
					tmr_ticks = cld_pkg::TK_CLEAR;
					d.cfg.addr_counter = cld_pkg::AC_HOME;
					d.cfg.display_shift = cld_pkg::SHIFT_HOME;
					d.to_glyph = 1'b0;
				end
				cld_pkg::OP_ENTRY: begin
					d.cfg.step_direction =
						q.instr_holding_reg[cld_pkg::ENTRY_DIR_BIT];
					d.cfg.follow_shift =
						q.instr_holding_reg[cld_pkg::ENTRY_SH_BIT];
				end
				cld_pkg::OP_DISP: begin
					d.cfg.display_on_bit =
						q.instr_holding_reg[cld_pkg::DISP_D_BIT];
					d.cfg.cursor_on_bit =
						q.instr_holding_reg[cld_pkg::DISP_C_BIT];
					d.cfg.blink_on_bit =
						q.instr_holding_reg[cld_pkg::DISP_B_BIT];
				end
				cld_pkg::OP_SHIFT: begin
					// Display shift leaves the counter alone
					if (q.instr_holding_reg[cld_pkg::SHIFT_SC_BIT]) begin
						d.cfg.display_shift = cld_pkg::step_ac(
							q.cfg.display_shift,
							~q.instr_holding_reg[cld_pkg::SHIFT_RL_BIT]);
					end else begin
						d.cfg.addr_counter = cld_pkg::step_ac(
							q.cfg.addr_counter,
							q.instr_holding_reg[cld_pkg::SHIFT_RL_BIT]);
					end
				end
				cld_pkg::OP_FUNC: begin
					d.cfg.bus_width_sel =
						q.instr_holding_reg[cld_pkg::FUNC_DL_BIT];
					d.cfg.line_count_sel =
						q.instr_holding_reg[cld_pkg::FUNC_N_BIT];
					d.cfg.font_height_sel =
						q.instr_holding_reg[cld_pkg::FUNC_F_BIT];
					d.half = 1'b0;
				end
				cld_pkg::OP_GLYPH: begin
					d.to_glyph = 1'b1;
					d.cfg.addr_counter =
						{1'b0, q.instr_holding_reg[5:0]};
				end
				cld_pkg::OP_TEXT: begin
					d.to_glyph = 1'b0;
					d.cfg.addr_counter = q.instr_holding_reg[6:0];
				end
				default: begin
					tmr_start = 1'b0;
				end
			endcase
		end

		// Data write into whichever RAM was last addressed
		if (q.dr_pend) begin
			tmr_start = 1'b1;
			tmr_ticks = cld_pkg::TK_DATA;
			text_we = ~q.to_glyph;
			glyph_we = q.to_glyph;
			d.cfg.addr_counter = cld_pkg::step_ac(q.cfg.addr_counter,
				q.cfg.step_direction);
			if (~q.to_glyph & q.cfg.follow_shift) begin
				// High direction shifts the picture left
				d.cfg.display_shift = cld_pkg::step_ac(
					q.cfg.display_shift, q.cfg.step_direction);
			end
		end

		// Data read steps the counter and starts the data busy time
		if (q.rd_pend) begin
			tmr_start = 1'b1;
			tmr_ticks = cld_pkg::TK_DATA;
			d.cfg.addr_counter = cld_pkg::step_ac(q.cfg.addr_counter,
				q.cfg.step_direction);
		end

		// One location per clock; far shorter than the busy time
		if (q.clearing) begin
			text_we = 1'b1;
			text_wa = q.fill;
			text_wd = cld_pkg::SPACE_CODE;
			d.fill = 7'(q.fill + cld_pkg::AC_STEP);
			d.clearing = (q.fill != cld_pkg::AC_LAST);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= cld_pkg::RST_STATE;
		end else begin
			q <= d;
		end
	end

	// RAM contents are not reset
	always_ff @(posedge clk) begin
		if (text_we) begin
			text_mem[text_wa] <= text_wd;
		end
		if (glyph_we) begin
			glyph_mem[q.cfg.addr_counter[5:0]] <= q.data_holding_reg;
		end
	end

	assign host_out = q.out;
	assign cfg = q.cfg;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence clear_exec;
		q.ir_pend && (op == cld_pkg::OP_CLEAR);
	endsequence

	sequence home_exec;
		q.ir_pend && (op == cld_pkg::OP_HOME);
	endsequence

	sequence spaces_written;
		(text_we && (text_wd == cld_pkg::SPACE_CODE))[*8];
	endsequence

	clear_fill_a: assert property (clear_exec |=> spaces_written)
		else $error("clear did not write space codes");

	clear_cursor_a: assert property (clear_exec |=>
		(q.cfg.addr_counter == cld_pkg::AC_HOME) && q.cfg.step_direction)
		else $error("clear did not home cursor or set increment");

	home_restore_a: assert property (home_exec |=>
		(q.cfg.addr_counter == cld_pkg::AC_HOME) && !q.clearing &&
		(q.cfg.display_shift == cld_pkg::SHIFT_HOME))
		else $error("home did not restore position");

	entry_store_a: assert property (
		q.ir_pend && (op == cld_pkg::OP_ENTRY) |=>
		(q.cfg.step_direction == $past(q.instr_holding_reg[1])) &&
		(q.cfg.follow_shift == $past(q.instr_holding_reg[0])))
		else $error("entry mode bits not stored");

	disp_store_a: assert property (
		q.ir_pend && (op == cld_pkg::OP_DISP) |=>
		({q.cfg.display_on_bit, q.cfg.cursor_on_bit, q.cfg.blink_on_bit}
		== $past(q.instr_holding_reg[2:0])))
		else $error("display control bits not stored");

	glyph_addr_a: assert property (
		q.ir_pend && (op == cld_pkg::OP_GLYPH) |=>
		q.to_glyph && (q.cfg.addr_counter ==
		{1'b0, $past(q.instr_holding_reg[5:0])}))
		else $error("glyph address not loaded");

	status_read_a: assert property (
		rise && status_rd && q.cfg.bus_width_sel |=>
		(q.out.bus_lines == {$past(busy_indicator),
		$past(q.cfg.addr_counter)}))
		else $error("status read value wrong");

	step_up_a: assert property (
		(q.dr_pend || q.rd_pend) && q.cfg.step_direction |=>
		(q.cfg.addr_counter == 7'($past(q.cfg.addr_counter) + 7'h01)))
		else $error("address counter did not increment");

	busy_hold_a: assert property (
		q.dr_pend |-> busy_indicator ##1 busy_indicator[*8])
		else $error("busy dropped during data execution");

	text_addr_a: assert property (
		q.ir_pend && (op == cld_pkg::OP_TEXT) |=>
		!q.to_glyph &&
		(q.cfg.addr_counter == $past(q.instr_holding_reg[6:0])))
		else $error("text address not loaded");

	func_store_a: assert property (
		q.ir_pend && (op == cld_pkg::OP_FUNC) |=>
		({q.cfg.bus_width_sel, q.cfg.line_count_sel,
		q.cfg.font_height_sel} == $past(q.instr_holding_reg[4:2])))
		else $error("function set bits not stored");

	disp_shift_a: assert property (
		q.ir_pend && (op == cld_pkg::OP_SHIFT) &&
		q.instr_holding_reg[cld_pkg::SHIFT_SC_BIT] |=>
		(q.cfg.addr_counter == $past(q.cfg.addr_counter)))
		else $error("display shift changed the address counter");

	step_down_a: assert property (
		(q.dr_pend || q.rd_pend) && !q.cfg.step_direction |=>
		(q.cfg.addr_counter == 7'($past(q.cfg.addr_counter) - 7'h01)))
		else $error("address counter did not decrement");

	// A refused strobe must leave no pending work behind
	busy_refuse_a: assert property (
		fall && busy_indicator && !status_rd |=>
		!q.ir_pend && !q.dr_pend && !q.rd_pend)
		else $error("transfer accepted while busy");

	data_capture_a: assert property (
		fall && !busy_indicator && !host_in.dir_select_line &&
		host_in.reg_select_line && q.cfg.bus_width_sel |=>
		q.dr_pend && (q.data_holding_reg == $past(host_in.bus_lines)))
		else $error("data byte not captured");

endmodule : cld_decoder
`default_nettype wire

/* logic/cld_pkg.sv */
// Shared constants, carriers and types of the character display decoder
package cld_pkg;

	// Clock and internal oscillator rates
	localparam int     CLK_HZ     = 50000000;
	localparam int     OSC_HZ     = 270000;
	localparam int     OSC_DIV    = CLK_HZ / OSC_HZ;
	localparam longint NS_PER_S   = 64'd1000000000;

	// Execution times at the nominal oscillator rate
	localparam longint T_CLEAR_NS = 64'd1530000;
	localparam longint T_INSTR_NS = 64'd39000;
	localparam longint T_DATA_NS  = 64'd43000;
	localparam int     TICK_W     = 9;

	function automatic logic [TICK_W-1:0] ns_to_ticks(input longint ns);
		return TICK_W'((ns * OSC_HZ + NS_PER_S - 64'd1) / NS_PER_S);
	endfunction : ns_to_ticks

	localparam logic [TICK_W-1:0] TK_CLEAR = ns_to_ticks(T_CLEAR_NS);
	localparam logic [TICK_W-1:0] TK_INSTR = ns_to_ticks(T_INSTR_NS);
	localparam logic [TICK_W-1:0] TK_DATA  = ns_to_ticks(T_DATA_NS);

	// Memory sizes and fixed codes
	localparam int          AC_W        = 7;
	localparam int          TEXT_DEPTH  = 128;
	localparam int          GLYPH_DEPTH = 64;
	localparam logic [7:0]  SPACE_CODE  = 8'h20;
	localparam logic [6:0]  AC_HOME     = 7'h00;
	localparam logic [6:0]  AC_LAST     = 7'h7F;
	localparam logic [6:0]  AC_STEP     = 7'h01;
	localparam logic [6:0]  SHIFT_HOME  = 7'h00;

	// Instruction field positions
	localparam int ENTRY_DIR_BIT = 1;
	localparam int ENTRY_SH_BIT  = 0;
	localparam int DISP_D_BIT    = 2;
	localparam int DISP_C_BIT    = 1;
	localparam int DISP_B_BIT    = 0;
	localparam int SHIFT_SC_BIT  = 3;
	localparam int SHIFT_RL_BIT  = 2;
	localparam int FUNC_DL_BIT   = 4;
	localparam int FUNC_N_BIT    = 3;
	localparam int FUNC_F_BIT    = 2;

	// Host pins as seen by the device
	typedef struct packed {
		logic       reg_select_line;
		logic       dir_select_line;
		logic       bus_strobe;
		logic [7:0] bus_lines;
	} cld_host_in_t;

	// Read data and its output enable
	typedef struct packed {
		logic [7:0] bus_lines;
		logic       bus_lines_oe;
	} cld_host_out_t;

	// Settings and position visible to the display side
	typedef struct packed {
		logic       display_on_bit;
		logic       cursor_on_bit;
		logic       blink_on_bit;
		logic       bus_width_sel;
		logic       line_count_sel;
		logic       font_height_sel;
		logic       step_direction;
		logic       follow_shift;
		logic [6:0] display_shift;
		logic [6:0] addr_counter;
	} cld_cfg_t;

	typedef enum {
		OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISP,
		OP_SHIFT, OP_FUNC, OP_GLYPH, OP_TEXT
	} cld_op_t;

	typedef struct packed {
		cld_cfg_t      cfg;
		logic          to_glyph;
		logic          strobe_prev;
		logic          half;
		logic [3:0]    hi_nib;
		logic [7:0]    instr_holding_reg;
		logic [7:0]    data_holding_reg;
		logic          ir_pend;
		logic          dr_pend;
		logic          rd_pend;
		cld_host_out_t out;
		logic          clearing;
		logic [6:0]    fill;
	} cld_state_t;

	localparam cld_cfg_t RST_CFG = '{
		display_on_bit:  1'b0,
		cursor_on_bit:   1'b0,
		blink_on_bit:    1'b0,
		bus_width_sel:   1'b1,
		line_count_sel:  1'b0,
		font_height_sel: 1'b0,
		step_direction:  1'b1,
		follow_shift:    1'b0,
		display_shift:   SHIFT_HOME,
		addr_counter:    AC_HOME
	};

	localparam cld_state_t RST_STATE = '{cfg: RST_CFG, default: '0};

	function automatic cld_op_t decode_op(input logic [7:0] b);
		if (b[7]) return OP_TEXT;
		if (b[6]) return OP_GLYPH;
		if (b[5]) return OP_FUNC;
		if (b[4]) return OP_SHIFT;
		if (b[3]) return OP_DISP;
		if (b[2]) return OP_ENTRY;
		if (b[1]) return OP_HOME;
		if (b[0]) return OP_CLEAR;
		return OP_NONE;
	endfunction : decode_op

	function automatic logic [6:0] step_ac(input logic [6:0] ac,
			input logic up);
		return up ? 7'(ac + AC_STEP) : 7'(ac - AC_STEP);
	endfunction : step_ac

endpackage : cld_pkg

/* verif/cld_host_model.sv */
// Host processor model driving the parallel display bus
`timescale 1ns/100ps
`default_nettype none
module cld_host_model #(
	parameter int OSC_DIV = 8
) (
	// Clock
	input  wire logic                   clk,
	// Device pins
	input  wire cld_pkg::cld_host_out_t host_out,
	output var  cld_pkg::cld_host_in_t  host_in,
	// Poll limit ran out
	output var  logic                   hung
);
	logic nib;
	logic oe_seen;
	initial begin
		host_in = '0;
		hung = 1'b0;
		nib = 1'b0;
		oe_seen = 1'b0;
	end
	task automatic set_nib(input logic v);
		nib = v;
	endtask : set_nib
	// Strobe high two clocks, select lines held one clock past the fall
	task automatic strobe(input logic sel, input logic rw,
			input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		host_in.reg_select_line = sel;
		host_in.dir_select_line = rw;
		host_in.bus_lines = rw ? ~host_in.bus_lines : d;
		host_in.bus_strobe = 1'b1;
		@(negedge clk);
		@(negedge clk);
		q = host_out.bus_lines;
		oe_seen = host_out.bus_lines_oe;
		host_in.bus_strobe = 1'b0;
		@(negedge clk);
		// Released lines never keep the old value
		host_in.bus_lines = ~host_in.bus_lines;
	endtask : strobe
	task automatic xfer(input logic sel, input logic rw,
			input logic [7:0] d, output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (nib) begin
			strobe(sel, rw, d, hi);
			strobe(sel, rw, {d[3:0], 4'h0}, lo);
			q = {hi[7:4], lo[7:4]};
		end else begin
			strobe(sel, rw, d, q);
		end
	endtask : xfer
	// Status reads until idle, then the half oscillator period gap
	task automatic poll();
		logic [7:0] s;
		int         n;
		s = 8'hFF;
		n = 0;
		while (s[7] === 1'b1 && n < 2000) begin
			xfer(1'b0, 1'b1, 8'h00, s);
			n++;
		end
		if (s[7] !== 1'b0) hung = 1'b1;
		repeat (OSC_DIV / 2 + 1) @(negedge clk);
	endtask : poll
endmodule : cld_host_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking testbench of the display instruction decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int DIV = 8;
	logic                   clk;
	logic                   rst;
	cld_pkg::cld_host_in_t  host_in;
	cld_pkg::cld_host_out_t host_out;
	logic                   busy_indicator;
	cld_pkg::cld_cfg_t      cfg;
	logic                   hung;
	int                     fails;
	int                     check_count;
	logic [7:0]             q;

	cld_decoder #(.OSC_DIV(DIV)) cld_decoder_inst (.clk(clk), .rst(rst),
		.host_in(host_in), .host_out(host_out),
		.busy_indicator(busy_indicator), .cfg(cfg));
	cld_host_model #(.OSC_DIV(DIV)) cld_host_model_inst (.clk(clk),
		.host_out(host_out), .host_in(host_in), .hung(hung));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	always @(posedge hung) begin
		fails++;
		print_verdict();
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic sel, input logic [7:0] d);
		cld_host_model_inst.xfer(sel, 1'b0, d, q);
		cld_host_model_inst.poll();
	endtask : wr
	task automatic rd(input logic sel);
		cld_host_model_inst.xfer(sel, 1'b1, 8'h00, q);
		cld_host_model_inst.poll();
	endtask : rd
	// Busy counted on falling edges; start lags the strobe by a clock
	task automatic busy_len(input int exp);
		int n;
		n = 0;
		while (busy_indicator === 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4000) begin
			fails++;
			print_verdict();
		end
		check("busy cycles", 32'(n >= exp - 1 && n <= exp + 2), 1);
		repeat (DIV / 2 + 1) @(negedge clk);
	endtask : busy_len
	task automatic t_clear();
		wr(1'b0, 8'h85);
		wr(1'b1, 8'h41);
		wr(1'b0, 8'h04);
		cld_host_model_inst.xfer(1'b0, 1'b0, 8'h01, q);
		busy_len(414 * DIV);
		check("addr", cfg.addr_counter, 7'h00);
		check("dir", cfg.step_direction, 1'b1);
		wr(1'b0, 8'h85);
		rd(1'b1);
		check("text 05", q, 8'h20);
		wr(1'b0, 8'hFF);
		rd(1'b1);
		check("text 7F", q, 8'h20);
	endtask : t_clear
	task automatic t_data();
		wr(1'b0, 8'h8A);
		cld_host_model_inst.xfer(1'b1, 1'b0, 8'hA5, q);
		busy_len(12 * DIV);
		wr(1'b1, 8'h5A);
		check("addr", cfg.addr_counter, 7'h0C);
		wr(1'b0, 8'h8A);
		rd(1'b1);
		check("text 0A", q, 8'hA5);
		check("addr", cfg.addr_counter, 7'h0B);
		wr(1'b0, 8'h04);
		wr(1'b1, 8'h77);
		check("addr", cfg.addr_counter, 7'h0A);
		rd(1'b0);
		check("status", q, 8'h0A);
		check("oe read", cld_host_model_inst.oe_seen, 1'b1);
		check("oe idle", host_out.bus_lines_oe, 1'b0);
		wr(1'b0, 8'h06);
	endtask : t_data
	task automatic t_refuse();
		cld_host_model_inst.xfer(1'b1, 1'b0, 8'h11, q);
		cld_host_model_inst.xfer(1'b0, 1'b1, 8'h00, q);
		check("busy bit", q[7], 1'b1);
		cld_host_model_inst.xfer(1'b1, 1'b0, 8'h22, q);
		check("oe write", cld_host_model_inst.oe_seen, 1'b0);
		cld_host_model_inst.poll();
		check("addr", cfg.addr_counter, 7'h0B);
		wr(1'b0, 8'h8A);
		rd(1'b1);
		check("text 0A", q, 8'h11);
		rd(1'b1);
		check("text 0B", q, 8'h77);
	endtask : t_refuse
	task automatic t_glyph();
		wr(1'b0, 8'h7F);
		wr(1'b1, 8'h3C);
		check("addr", cfg.addr_counter, 7'h40);
		wr(1'b0, 8'h7F);
		rd(1'b1);
		check("glyph 3F", q, 8'h3C);
		wr(1'b0, 8'h8A);
		rd(1'b1);
		check("text 0A", q, 8'h11);
	endtask : t_glyph
	task automatic t_settings();
		cld_host_model_inst.xfer(1'b0, 1'b0, 8'h0D, q);
		busy_len(11 * DIV);
		check("disp", {cfg.display_on_bit, cfg.cursor_on_bit,
			cfg.blink_on_bit}, 3'b101);
		wr(1'b0, 8'h0A);
		check("disp", {cfg.display_on_bit, cfg.cursor_on_bit,
			cfg.blink_on_bit}, 3'b010);
		wr(1'b0, 8'h3C);
		check("func", {cfg.bus_width_sel, cfg.line_count_sel,
			cfg.font_height_sel}, 3'b111);
		wr(1'b0, 8'h30);
		check("func", {cfg.bus_width_sel, cfg.line_count_sel,
			cfg.font_height_sel}, 3'b100);
	endtask : t_settings
	task automatic t_shift();
		wr(1'b0, 8'h90);
		cld_host_model_inst.xfer(1'b0, 1'b0, 8'h14, q);
		busy_len(11 * DIV);
		check("addr", cfg.addr_counter, 7'h11);
		wr(1'b0, 8'h10);
		check("addr", cfg.addr_counter, 7'h10);
		wr(1'b0, 8'h18);
		check("shift", {cfg.display_shift, cfg.addr_counter},
			{7'h01, 7'h10});
		wr(1'b0, 8'h1C);
		check("shift", cfg.display_shift, 7'h00);
		wr(1'b0, 8'h18);
		cld_host_model_inst.xfer(1'b0, 1'b0, 8'h03, q);
		busy_len(414 * DIV);
		check("home", {cfg.display_shift, cfg.addr_counter}, 14'h0);
		wr(1'b0, 8'h8A);
		rd(1'b1);
		check("text 0A", q, 8'h11);
		wr(1'b0, 8'h07);
		wr(1'b0, 8'h90);
		wr(1'b1, 8'h55);
		check("shift", cfg.display_shift, 7'h01);
		wr(1'b0, 8'h90);
		rd(1'b1);
		wr(1'b0, 8'h40);
		wr(1'b1, 8'h66);
		check("shift", cfg.display_shift, 7'h01);
		wr(1'b0, 8'h06);
	endtask : t_shift
	task automatic t_nibble();
		// Single-strobe polls would split nibble pairs once narrow mode starts
		cld_host_model_inst.xfer(1'b0, 1'b0, 8'h28, q);
		busy_len(11 * DIV);
		check("width", cfg.bus_width_sel, 1'b0);
		cld_host_model_inst.set_nib(1'b1);
		wr(1'b0, 8'hC5);
		wr(1'b1, 8'h9C);
		check("addr", cfg.addr_counter, 7'h46);
		wr(1'b0, 8'hC5);
		rd(1'b1);
		check("text 45", q, 8'h9C);
		rd(1'b0);
		check("status", q, 8'h46);
		wr(1'b0, 8'h38);
		cld_host_model_inst.set_nib(1'b0);
		check("width", cfg.bus_width_sel, 1'b1);
	endtask : t_nibble
	initial begin
		fails = 0;
		check_count = 0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check("reset", {busy_indicator, cfg.bus_width_sel,
			cfg.step_direction, cfg.addr_counter}, {3'b011, 7'h00});
		t_clear();
		t_data();
		t_refuse();
		t_glyph();
		t_settings();
		t_shift();
		t_nibble();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
